/* common/cmts_pkg.sv */
// Functional notes
// [RQ1] bus-off left by software, or automatically after 128 x 11 recessive bits
// [RQ2] auto wake-up on start of frame clears sleep request and acknowledge
// [RQ3] single-shot mode sends each message once, otherwise retry until success
// [RQ4] full receive FIFO overwrites when unlocked, discards new message when locked
// [RQ5] pending mailboxes ordered by identifier or by request order
// [RQ6] sleep entered after current frame; clearing request leaves sleep
// [RQ7] leaving init waits for 11 recessive bits, then clears init acknowledge
// [RQ8] init request waits for current frame, then sets init acknowledge
// [RQ9] status flags clear by writing one; zero leaves them unchanged
// [RQ10] read-only bits show receiver and transmitter activity
// [RQ11] start of frame in sleep sets wake-up flag, interrupt when enabled
// [RQ12] enabled error-status event sets error flag, interrupt when enabled
// [RQ13] sleep acknowledge set in sleep, cleared by hardware on leaving
// [RQ14] init acknowledge set in init, cleared after leaving and synchronised
// [RQ15] success flag set on good send, cleared by new request or done clear
// [RQ16] request-done flag set when transmit or abort finishes, software clears
// [RQ17] lowest-priority flag only when both pending, else both read zero
// [RQ18] reserved status and priority bits read zero; control top bit kept clear
// [RQ19] empty flag per idle mailbox; code gives free or lowest-priority box
// [RQ20] transmit interrupt while any request-done flag is set and enabled
// [RQ21] hardware flag set wins over simultaneous software clear
package cmts_pkg;
    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_MCTL  = 8'h00;
    localparam logic [7:0] OFS_MSTAT = 8'h04;
    localparam logic [7:0] OFS_TSTAT = 8'h08;
    localparam logic [7:0] OFS_TPRIO = 8'h0c;
    localparam logic [7:0] OFS_IEN   = 8'h10;
    localparam logic [7:0] OFS_EIEN  = 8'h14;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int B_AUTO_REC = 6, B_AUTO_WAKE = 5, B_SSHOT = 4, B_LOCK = 3;
    localparam int B_ORDER = 2, B_SLEEP = 1, B_INIT = 0;
    localparam int B_RX = 5, B_TX = 4, B_WAKE = 3, B_ERR = 2;
    localparam int B_SLEEP_ACK = 1, B_INIT_ACK = 0;
    localparam int B_OK0 = 4, B_DONE0 = 0;
    localparam int B_LOWEST_PRIO_BOX0 = 5, B_EMPTY0 = 2, B_CODE = 0;
    localparam int B_WKIE = 7, B_TMIE = 0, B_ERR_IE = 7;
    // ---------------------------------------------------------------
    // reset values and counts
    // ---------------------------------------------------------------
    localparam logic [7:0] MCTL_RST  = 8'h02;
    localparam logic [7:0] MSTAT_RST = 8'h02;
    localparam logic [7:0] TPRIO_RST = 8'h0c;
    localparam logic [3:0] SYNC_BITS = 4'hb;
    localparam logic [7:0] BOFF_SEQS = 8'h80;
    localparam logic [31:0] RD_ZERO  = 32'h0000_0000;

    typedef enum logic [2:0] {
        CMTS_NORMAL = 3'b000,
        CMTS_INIT   = 3'b001,
        CMTS_SYNC   = 3'b010,
        CMTS_SLEEP  = 3'b011,
        CMTS_BOFF   = 3'b100
    } cmts_state_t;
endpackage

/* hdl/cmts_top.sv */
`timescale 1ns/1ps
`default_nettype none
module cmts_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_bit,
    input  wire logic        bit_tick,
    input  wire logic        sof_seen,
    input  wire logic        frame_busy,
    input  wire logic        receiving_now,
    input  wire logic        transmitting_now,
    input  wire logic        busoff_enter,
    input  wire logic [3:0]  err_event,
    input  wire logic [1:0]  tx_req,
    input  wire logic [1:0]  tx_ok,
    input  wire logic [1:0]  tx_fail,
    input  wire logic [1:0]  tx_abort,
    input  wire logic        box1_id_wins,
    input  wire logic        rx_arrive,
    input  wire logic        rx_fifo_full,
    output logic             can_online,
    output logic             can_busoff,
    output logic             tx_pick,
    output logic             tx_pick_valid,
    output logic             rx_overwrite,
    output logic             rx_discard,
    output logic             status_irq,
    output logic             tx_irq
);
    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    logic setup, wr;
    logic [7:0] wb;
    assign setup = psel & ~penable;
    assign wr    = psel & penable & pready & pwrite;
    assign wb    = pwdata[7:0];

    logic [6:0] mctl_q;
    logic [1:0] ien_q;
    logic [4:0] eien_q;
    logic wake_q, err_q, sleep_ack_q, init_ack_q, recv_q, tran_q;
    logic [1:0] ok_q, done_q, pend_q;
    logic first_q;
    cmts_pkg::cmts_state_t st_q;

    logic mw, sw_w, tw, iw, ew;
    assign mw   = wr && paddr == cmts_pkg::OFS_MCTL;
    assign sw_w = wr && paddr == cmts_pkg::OFS_MSTAT;
    assign tw   = wr && paddr == cmts_pkg::OFS_TSTAT;
    assign iw   = wr && paddr == cmts_pkg::OFS_IEN;
    assign ew   = wr && paddr == cmts_pkg::OFS_EIEN;

    logic auto_rec, auto_wake, sshot, lock, order, sleep_rq, init_rq;
    assign auto_rec  = mctl_q[cmts_pkg::B_AUTO_REC];
    assign auto_wake = mctl_q[cmts_pkg::B_AUTO_WAKE];
    assign sshot    = mctl_q[cmts_pkg::B_SSHOT];
    assign lock     = mctl_q[cmts_pkg::B_LOCK];
    assign order    = mctl_q[cmts_pkg::B_ORDER];
    assign sleep_rq = mctl_q[cmts_pkg::B_SLEEP];
    assign init_rq  = mctl_q[cmts_pkg::B_INIT];

    // ---------------------------------------------------------------
    // recessive bit counting
    // ---------------------------------------------------------------
    // one bit counter serves both sync (11 bits) and bus-off recovery, where seq_q counts the 128 runs of 11
    logic [3:0] rcnt_q;
    logic [7:0] seq_q;
    logic run11, run_boff;
    assign run11    = bit_tick && rx_bit && rcnt_q == cmts_pkg::SYNC_BITS - 4'h1;
    assign run_boff = run11 && seq_q == cmts_pkg::BOFF_SEQS - 8'h01;
    // the count restarts whenever the state leaves sync or bus-off

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rcnt_q <= 4'h0;
            seq_q  <= 8'h00;
        end else if (st_q != cmts_pkg::CMTS_SYNC && st_q != cmts_pkg::CMTS_BOFF) begin
            rcnt_q <= 4'h0;
            seq_q  <= 8'h00;
        end else if (bit_tick) begin
            if (!rx_bit) begin
                rcnt_q <= 4'h0; // a dominant bit restarts the run
            end else if (run11) begin
                rcnt_q <= 4'h0;
                seq_q  <= seq_q + 8'h01;
            end else begin
                rcnt_q <= rcnt_q + 4'h1;
            end
        end
    end

    // ---------------------------------------------------------------
    // mode state machine
    // ---------------------------------------------------------------
    logic wake_ev;
    assign wake_ev = st_q == cmts_pkg::CMTS_SLEEP && sof_seen;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= cmts_pkg::CMTS_SLEEP;
        end else begin
            unique case (st_q)
                cmts_pkg::CMTS_NORMAL: begin
                    if (busoff_enter) begin
                        st_q <= cmts_pkg::CMTS_BOFF;
                    end else if (init_rq && !frame_busy) begin
                        st_q <= cmts_pkg::CMTS_INIT; // RQ8
                    end else if (sleep_rq && !frame_busy) begin
                        st_q <= cmts_pkg::CMTS_SLEEP; // RQ6
                    end
                end
                cmts_pkg::CMTS_INIT: begin
                    if (!init_rq) begin
                        st_q <= cmts_pkg::CMTS_SYNC;
                    end
                end
                cmts_pkg::CMTS_SYNC: begin
                    if (init_rq) begin
                        st_q <= cmts_pkg::CMTS_INIT;
                    end else if (run11) begin
                        st_q <= cmts_pkg::CMTS_NORMAL; // RQ7
                    end
                end
                cmts_pkg::CMTS_SLEEP: begin
                    if (init_rq) begin
                        st_q <= cmts_pkg::CMTS_INIT;
                    end else if (!sleep_rq || (auto_wake && sof_seen)) begin
                        st_q <= cmts_pkg::CMTS_NORMAL; // RQ2 RQ6
                    end
                end
                cmts_pkg::CMTS_BOFF: begin
                    // without auto recovery, software leaves via init request
                    if (init_rq) begin
                        st_q <= cmts_pkg::CMTS_INIT; // RQ1
                    end else if (auto_rec && run_boff) begin
                        st_q <= cmts_pkg::CMTS_NORMAL; // RQ1
                    end
                end
                default: st_q <= cmts_pkg::CMTS_SLEEP;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // control and enable registers
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mctl_q <= cmts_pkg::MCTL_RST[6:0];
        end else begin
            if (mw) begin
                mctl_q <= wb[6:0]; // RQ18
            end
            // hardware clear of the sleep request beats a same-cycle write
            if (auto_wake && wake_ev) begin
                mctl_q[cmts_pkg::B_SLEEP] <= 1'b0; // RQ2
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ien_q  <= 2'b00;
            eien_q <= 5'h00;
        end else begin
            if (iw) begin
                ien_q <= {wb[cmts_pkg::B_WKIE], wb[cmts_pkg::B_TMIE]};
            end
            if (ew) begin
                eien_q <= {wb[cmts_pkg::B_ERR_IE], wb[4], wb[2:0]};
            end
        end
    end

    // ---------------------------------------------------------------
    // master status flags
    // ---------------------------------------------------------------
    logic err_ev;
    assign err_ev = |(err_event & eien_q[3:0]); // RQ12

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_q <= 1'b0;
            err_q  <= 1'b0;
        end else begin
            // a same-cycle write of one never swallows a new event
            if (wake_ev) begin
                wake_q <= 1'b1; // RQ11 RQ21
            end else if (sw_w && wb[cmts_pkg::B_WAKE]) begin
                wake_q <= 1'b0; // RQ9
            end
            if (err_ev) begin
                err_q <= 1'b1; // RQ12 RQ21
            end else if (sw_w && wb[cmts_pkg::B_ERR]) begin
                err_q <= 1'b0; // RQ9
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_ack_q <= cmts_pkg::MSTAT_RST[cmts_pkg::B_SLEEP_ACK];
            init_ack_q  <= cmts_pkg::MSTAT_RST[cmts_pkg::B_INIT_ACK];
            recv_q <= 1'b0;
            tran_q <= 1'b0;
        end else begin
            // acknowledges set one cycle after entry; sleep ack clears on the edge sleep is left, or one cycle later when left for init;
            // init ack clears on the edge sync completes; software polls them
            sleep_ack_q <= st_q == cmts_pkg::CMTS_SLEEP && !(auto_wake && sof_seen) && sleep_rq; // RQ13
            init_ack_q  <= st_q == cmts_pkg::CMTS_INIT
                           || (st_q == cmts_pkg::CMTS_SYNC && !run11); // RQ14
            recv_q <= receiving_now; // RQ10
            tran_q <= transmitting_now; // RQ10
        end
    end

    // ---------------------------------------------------------------
    // transmit mailboxes
    // ---------------------------------------------------------------
    logic [1:0] fin, clr_done;
    // an outcome for a box that is not pending is stale and ignored
    assign fin      = pend_q & (tx_ok | tx_abort | (sshot ? tx_fail : 2'b00)); // RQ3
    assign clr_done = tw ? wb[cmts_pkg::B_DONE0 +: 2] : 2'b00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 2'b00;
            done_q <= 2'b00;
            ok_q   <= 2'b00;
        end else begin
            pend_q <= (pend_q & ~fin) | tx_req;
            done_q <= (done_q & ~clr_done) | fin; // RQ16 RQ9 RQ21
            ok_q   <= (ok_q & ~clr_done & ~tx_req) | (pend_q & tx_ok); // RQ15 RQ21
        end
    end

    // oldest request is remembered; a lone request becomes the oldest
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_q <= 1'b0;
        end else if (tx_req[0] && !(pend_q[1] & ~fin[1])) begin
            first_q <= 1'b0;
        end else if (tx_req[1] && !(pend_q[0] & ~fin[0])) begin
            first_q <= 1'b1;
        end else if (fin[first_q]) begin
            first_q <= ~first_q;
        end
    end

    logic win, both;
    assign win  = order ? first_q : box1_id_wins; // RQ5
    assign both = &pend_q;
    // nothing is offered for sending outside normal mode

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_pick       <= 1'b0;
            tx_pick_valid <= 1'b0;
        end else begin
            tx_pick       <= both ? win : pend_q[1];
            tx_pick_valid <= |pend_q & (st_q == cmts_pkg::CMTS_NORMAL);
        end
    end

    // ---------------------------------------------------------------
    // receive FIFO full handling
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_overwrite <= 1'b0;
            rx_discard   <= 1'b0;
        end else begin
            // only the decision is made here; storage lives in the fifo itself
            rx_overwrite <= rx_arrive && rx_fifo_full && !lock; // RQ4
            rx_discard   <= rx_arrive && rx_fifo_full && lock; // RQ4
        end
    end

    // ---------------------------------------------------------------
    // mode outputs and interrupts
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            can_online <= 1'b0;
            can_busoff <= 1'b0;
            status_irq <= 1'b0;
            tx_irq     <= 1'b0;
        end else begin
            can_online <= st_q == cmts_pkg::CMTS_NORMAL;
            can_busoff <= st_q == cmts_pkg::CMTS_BOFF;
            // interrupt lines are levels that follow the flags one cycle late
            status_irq <= (wake_q & ien_q[1]) | (err_q & eien_q[4]); // RQ11 RQ12
            tx_irq     <= ien_q[0] & |done_q; // RQ20
        end
    end

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    logic [7:0] rd;
    logic hit;
    logic [1:0] low;
    logic code;
    assign low  = both ? {~win, win} : 2'b00; // RQ17
    assign code = !pend_q[0] ? 1'b0 : !pend_q[1] ? 1'b1 : ~win; // RQ19

    // unmapped offsets read zero and answer with an error
    always_comb begin
        rd  = 8'h00;
        hit = 1'b1;
        unique case (paddr)
            cmts_pkg::OFS_MCTL:  rd = {1'b0, mctl_q};
            cmts_pkg::OFS_MSTAT: rd = {2'b00, recv_q, tran_q, wake_q, err_q, sleep_ack_q, init_ack_q}; // RQ18
            cmts_pkg::OFS_TSTAT: rd = {2'b00, ok_q, 2'b00, done_q};
            cmts_pkg::OFS_TPRIO: rd = {1'b0, low, 1'b0, ~pend_q, 1'b0, code}; // RQ19
            cmts_pkg::OFS_IEN:   rd = {ien_q[1], 6'h00, ien_q[0]};
            cmts_pkg::OFS_EIEN:  rd = {eien_q[4], 2'b00, eien_q[3], 1'b0, eien_q[2:0]};
            default:             hit = 1'b0;
        endcase
    end

    // answer is registered in the setup cycle: one access cycle, no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= cmts_pkg::RD_ZERO;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~hit;
            prdata  <= setup ? {24'h000000, rd} : cmts_pkg::RD_ZERO;
        end
    end
endmodule
`default_nettype wire

/* sim/cmts_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module cmts_monitor (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic        rx_arrive,
    input  wire logic        rx_fifo_full,
    input  wire logic        rx_overwrite,
    input  wire logic        rx_discard,
    input  wire logic        busoff_enter,
    input  wire logic        can_busoff,
    input  wire logic        can_online,
    input  wire logic        tx_pick_valid
);
    logic lock_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // shadow of the fifo lock control, taken at the apb write edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            lock_q <= 1'b0;
        else if (psel && penable && pready && pwrite && paddr == cmts_pkg::OFS_MCTL)
            lock_q <= pwdata[cmts_pkg::B_LOCK];
    end
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_unmapped_err: assert property (pready |-> pslverr == (paddr > 8'h14 || paddr[1:0] != 2'b00))
        else $error("pslverr wrong for address");
    a_status_reserved: assert property (pready && !pwrite && paddr == cmts_pkg::OFS_MSTAT |-> prdata[31:6] == '0)
        else $error("status reserved bits set");
    a_prio_reserved: assert property (pready && !pwrite && paddr == cmts_pkg::OFS_TPRIO |-> prdata[31:7] == '0 && !prdata[4] && !prdata[1])
        else $error("priority reserved bits set");
    a_fifo_full_action: assert property (rx_arrive && rx_fifo_full |=> rx_discard == lock_q && rx_overwrite == !lock_q)
        else $error("full fifo action wrong");
    a_fifo_quiet: assert property (!(rx_arrive && rx_fifo_full) |=> !rx_discard && !rx_overwrite)
        else $error("fifo action without cause");
    a_busoff_entry: assert property (busoff_enter |-> ##[1:2] can_busoff)
        else $error("bus-off not entered");
    a_pick_online: assert property (tx_pick_valid |-> can_online && !can_busoff)
        else $error("pick offered while offline");
endmodule
bind cmts_top cmts_monitor cmts_monitor_inst (.*);
`default_nettype wire

/* sim/cmts_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cmts_bus_model (
    input  wire logic  pclk,
    output logic       rx_bit,
    output logic       bit_tick,
    output logic       sof_seen,
    output logic       frame_busy,
    output logic       receiving_now,
    output logic       transmitting_now,
    output logic       busoff_enter,
    output logic [3:0] err_event,
    output logic [1:0] tx_req,
    output logic [1:0] tx_ok,
    output logic [1:0] tx_fail,
    output logic [1:0] tx_abort,
    output logic       box1_id_wins,
    output logic       rx_arrive,
    output logic       rx_fifo_full
);
    logic [14:0] ev = '0;
    assign {tx_abort, tx_req, tx_fail, tx_ok, err_event, rx_arrive, busoff_enter, sof_seen} = ev;
    // idle bus is recessive; levels are moved by the bench as frames come and go
    initial begin
        {bit_tick, frame_busy, receiving_now, transmitting_now, box1_id_wins, rx_fifo_full} = '0;
        rx_bit = 1'b1;
    end
    // one-cycle event pulses, with a quiet cycle after so calls never collide
    task automatic fire(input logic [14:0] m);
        ev <= m;
        @(posedge pclk);
        ev <= '0;
        @(posedge pclk);
    endtask
    task automatic bits(input int n, input logic v);
        repeat (n) begin
            rx_bit <= v;
            bit_tick <= 1'b1;
            @(posedge pclk);
            bit_tick <= 1'b0;
            @(posedge pclk);
        end
        rx_bit <= 1'b1;
    endtask
endmodule
`default_nettype wire

/* sim/cmts_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHECK(what, exp, got) \
    checks++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("Error %s expected %h seen %h", what, exp, got); \
    end
module cmts_test;
    localparam logic [14:0] SOF = 15'h0001, BOFF = 15'h0002, ARR = 15'h0004, EWG = 15'h0008, EPV = 15'h0010;
    localparam logic [14:0] OK0 = 15'h0080, OK1 = 15'h0100, FAIL1 = 15'h0400, REQ0 = 15'h0800, REQ1 = 15'h1000;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic rx_bit, bit_tick, sof_seen, frame_busy, receiving_now, transmitting_now, busoff_enter;
    logic box1_id_wins, rx_arrive, rx_fifo_full, can_online, can_busoff, tx_pick, tx_pick_valid;
    logic rx_overwrite, rx_discard, status_irq, tx_irq;
    logic [3:0] err_event;
    logic [1:0] tx_req, tx_ok, tx_fail, tx_abort;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;
    cmts_top cmts_top_inst (.*);
    cmts_bus_model cmts_bus_model_inst (.*);
    initial pclk = 1'b0;
    always #10 pclk = ~pclk;
    // ------------------------------------------------
    // bus access
    // ------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        apb(1'b1, a, {24'h000000, d}, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] r;
        apb(1'b0, a, 32'h00000000, r);
        `CHECK("prdata", {24'h000000, e}, r)
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // cut a hang short; the whole run needs about 5900 cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            test_done;
        end
    end
    // ------------------------------------------------
    // sequence
    // ------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite} = '0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(cmts_pkg::OFS_MCTL, 8'h02);
        rd(cmts_pkg::OFS_MSTAT, 8'h02);
        rd(cmts_pkg::OFS_TSTAT, 8'h00);
        rd(cmts_pkg::OFS_TPRIO, 8'h0c);
        rd(8'h18, 8'h00);
        `CHECK("pslverr", 1'b1, slv)
        wr(cmts_pkg::OFS_TPRIO, 8'hff);
        rd(cmts_pkg::OFS_TPRIO, 8'h0c);
        cmts_bus_model_inst.fire(SOF);
        rd(cmts_pkg::OFS_MCTL, 8'h02);
        rd(cmts_pkg::OFS_MSTAT, 8'h0a);
        wr(cmts_pkg::OFS_MSTAT, 8'h08);
        cmts_bus_model_inst.receiving_now <= 1'b1;
        cmts_bus_model_inst.transmitting_now <= 1'b1;
        wr(cmts_pkg::OFS_MCTL, 8'h00);
        repeat (4) @(posedge pclk);
        rd(cmts_pkg::OFS_MSTAT, 8'h30);
        cmts_bus_model_inst.receiving_now <= 1'b0;
        cmts_bus_model_inst.transmitting_now <= 1'b0;
        wr(cmts_pkg::OFS_IEN, 8'h01);
        cmts_bus_model_inst.fire(REQ0);
        cmts_bus_model_inst.fire(OK0);
        rd(cmts_pkg::OFS_TSTAT, 8'h11);
        `CHECK("tx_irq", 1'b1, tx_irq)
        wr(cmts_pkg::OFS_TSTAT, 8'h00);
        rd(cmts_pkg::OFS_TSTAT, 8'h11);
        wr(cmts_pkg::OFS_TSTAT, 8'h01);
        rd(cmts_pkg::OFS_TSTAT, 8'h00);
        `CHECK("tx_irq", 1'b0, tx_irq)
        wr(cmts_pkg::OFS_MCTL, 8'h10);
        cmts_bus_model_inst.fire(REQ1);
        cmts_bus_model_inst.fire(FAIL1);
        rd(cmts_pkg::OFS_TSTAT, 8'h02);
        rd(cmts_pkg::OFS_TPRIO, 8'h0c);
        wr(cmts_pkg::OFS_TSTAT, 8'h02);
        wr(cmts_pkg::OFS_MCTL, 8'h00);
        cmts_bus_model_inst.fire(REQ1);
        cmts_bus_model_inst.fire(FAIL1);
        rd(cmts_pkg::OFS_TPRIO, 8'h04);
        cmts_bus_model_inst.fire(REQ0);
        rd(cmts_pkg::OFS_TPRIO, 8'h41);
        `CHECK("tx_pick", 1'b0, tx_pick)
        cmts_bus_model_inst.box1_id_wins <= 1'b1;
        rd(cmts_pkg::OFS_TPRIO, 8'h20);
        cmts_bus_model_inst.box1_id_wins <= 1'b0;
        wr(cmts_pkg::OFS_MCTL, 8'h04);
        rd(cmts_pkg::OFS_TPRIO, 8'h20);
        `CHECK("tx_pick", 1'b1, tx_pick)
        cmts_bus_model_inst.fire(OK0 | OK1);
        rd(cmts_pkg::OFS_TSTAT, 8'h33);
        cmts_bus_model_inst.fire(REQ0);
        rd(cmts_pkg::OFS_TSTAT, 8'h23);
        wr(cmts_pkg::OFS_TSTAT, 8'h03);
        cmts_bus_model_inst.fire(15'h2000);
        rd(cmts_pkg::OFS_TSTAT, 8'h01);
        wr(cmts_pkg::OFS_TSTAT, 8'h01);
        cmts_bus_model_inst.rx_fifo_full <= 1'b1;
        cmts_bus_model_inst.fire(ARR);
        wr(cmts_pkg::OFS_MCTL, 8'h08);
        cmts_bus_model_inst.fire(ARR);
        cmts_bus_model_inst.rx_fifo_full <= 1'b0;
        wr(cmts_pkg::OFS_EIEN, 8'h81);
        cmts_bus_model_inst.fire(EPV);
        rd(cmts_pkg::OFS_MSTAT, 8'h00);
        cmts_bus_model_inst.fire(EWG);
        rd(cmts_pkg::OFS_MSTAT, 8'h04);
        `CHECK("status_irq", 1'b1, status_irq)
        wr(cmts_pkg::OFS_MSTAT, 8'h04);
        rd(cmts_pkg::OFS_MSTAT, 8'h00);
        wr(cmts_pkg::OFS_IEN, 8'h80);
        wr(cmts_pkg::OFS_MCTL, 8'h22);
        repeat (4) @(posedge pclk);
        rd(cmts_pkg::OFS_MSTAT, 8'h02);
        cmts_bus_model_inst.fire(SOF);
        repeat (3) @(posedge pclk);
        rd(cmts_pkg::OFS_MCTL, 8'h20);
        rd(cmts_pkg::OFS_MSTAT, 8'h08);
        `CHECK("status_irq", 1'b1, status_irq)
        `CHECK("can_online", 1'b1, can_online)
        wr(cmts_pkg::OFS_MSTAT, 8'h08);
        cmts_bus_model_inst.frame_busy <= 1'b1;
        wr(cmts_pkg::OFS_MCTL, 8'h01);
        repeat (4) @(posedge pclk);
        rd(cmts_pkg::OFS_MSTAT, 8'h00);
        cmts_bus_model_inst.frame_busy <= 1'b0;
        repeat (4) @(posedge pclk);
        rd(cmts_pkg::OFS_MSTAT, 8'h01);
        wr(cmts_pkg::OFS_MCTL, 8'h00);
        cmts_bus_model_inst.bits(10, 1'b1);
        cmts_bus_model_inst.bits(1, 1'b0);
        cmts_bus_model_inst.bits(10, 1'b1);
        rd(cmts_pkg::OFS_MSTAT, 8'h01);
        cmts_bus_model_inst.bits(1, 1'b1);
        repeat (3) @(posedge pclk);
        rd(cmts_pkg::OFS_MSTAT, 8'h00);
        wr(cmts_pkg::OFS_MCTL, 8'h40);
        cmts_bus_model_inst.fire(BOFF);
        cmts_bus_model_inst.bits(1407, 1'b1);
        `CHECK("can_busoff", 1'b1, can_busoff)
        cmts_bus_model_inst.bits(1, 1'b1);
        repeat (3) @(posedge pclk);
        `CHECK("can_busoff", 1'b0, can_busoff)
        wr(cmts_pkg::OFS_MCTL, 8'h00);
        cmts_bus_model_inst.fire(BOFF);
        cmts_bus_model_inst.bits(1408, 1'b1);
        `CHECK("can_busoff", 1'b1, can_busoff)
        test_done;
    end
endmodule
`default_nettype wire
